//--- src/operand_address_sequencer.sv
// Contract
// - Immediate: opcode cycle, then operand at next location.
// - Immediate only for arithmetic, logic, compare, loads.
// - Absolute: opcode, address low, address high.
// - Cycle three fetches high, holds low byte.
// - Cycle four drives effective address, reads or writes.
// - Previous result commits during new opcode fetch.
// - Next opcode fetch follows effective-address cycle.
// - Jump and call load program counter, three cycles.
// - Other absolute instructions take four cycles.
// - Absolute accepted for listed operation classes.
// - Zero page: opcode plus one address byte.
// - Zero page forces high address byte zero.
// - Zero page takes three cycles, then fetch.
// - Zero-page operand cycle reads or writes page zero.
// - Pages of 256; page used only there.
// - Fetch cycles drive and increment program counter.
// - Zero page accepted except jump and call.
// - Immediate instruction occupies two program bytes.
// - Every instruction takes at least two cycles.
module operand_address_sequencer (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  read_data_i,
  input  wire logic [7:0]  accumulator_i,
  input  wire logic [7:0]  index_x_i,
  input  wire logic [7:0]  index_y_i,
  output logic      [15:0] address_o,
  output logic      [7:0]  write_data_o,
  output logic             write_enable_o,
  output logic             opcode_fetch_o,
  output logic             commit_o,
  output logic      [7:0]  opcode_o,
  output logic      [7:0]  operand_o,
  output logic             operand_valid_o,
  output logic             illegal_opcode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the sequencer, held as one record.
  typedef struct packed {
    operand_address_sequencer_pkg::seq_state_t state;
    logic [15:0]                               program_counter_value;
    logic [15:0]                               address;
    logic [7:0]                                opcode;
    logic [7:0]                                effective_address_low_byte;
    logic [7:0]                                write_data;
    logic                                      write_enable;
    logic [7:0]                                operand;
    logic                                      operand_valid;
    logic                                      commit;
    logic                                      illegal;
    logic                                      opcode_fetch;
  } seq_regs_t;

  localparam seq_regs_t REGS_RESET = '{
    state:                      operand_address_sequencer_pkg::ST_FETCH_OPCODE,
    program_counter_value:      operand_address_sequencer_pkg::COUNTER_RESET,
    address:                    operand_address_sequencer_pkg::COUNTER_RESET,
    opcode:                     operand_address_sequencer_pkg::BYTE_RESET,
    effective_address_low_byte: operand_address_sequencer_pkg::BYTE_RESET,
    write_data:                 operand_address_sequencer_pkg::BYTE_RESET,
    write_enable:               1'b0,
    operand:                    operand_address_sequencer_pkg::BYTE_RESET,
    operand_valid:              1'b0,
    commit:                     1'b0,
    illegal:                    1'b0,
    opcode_fetch:               1'b1
  };

  seq_regs_t                                 r;
  seq_regs_t                                 next_r;
  logic [15:0]                               counter_inc;
  operand_address_sequencer_pkg::operation_t cur_oper;
  operand_address_sequencer_pkg::addr_mode_t cur_mode;
  operand_address_sequencer_pkg::operation_t new_oper;
  operand_address_sequencer_pkg::addr_mode_t new_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True where the operation accepts the addressing mode.
  function automatic logic mode_allowed(
    input operand_address_sequencer_pkg::operation_t op,
    input operand_address_sequencer_pkg::addr_mode_t m
  );
    logic ok;
    ok = 1'b0;
    case (op)
      operand_address_sequencer_pkg::OPER_ADD,
      operand_address_sequencer_pkg::OPER_SUB,
      operand_address_sequencer_pkg::OPER_AND,
      operand_address_sequencer_pkg::OPER_OR,
      operand_address_sequencer_pkg::OPER_XOR,
      operand_address_sequencer_pkg::OPER_CMP_ACC,
      operand_address_sequencer_pkg::OPER_CMP_X,
      operand_address_sequencer_pkg::OPER_CMP_Y,
      operand_address_sequencer_pkg::OPER_LOAD_ACC,
      operand_address_sequencer_pkg::OPER_LOAD_X,
      operand_address_sequencer_pkg::OPER_LOAD_Y:
        ok = (m != operand_address_sequencer_pkg::MODE_OTHER);
      operand_address_sequencer_pkg::OPER_SHIFT_LEFT,
      operand_address_sequencer_pkg::OPER_SHIFT_RIGHT,
      operand_address_sequencer_pkg::OPER_ROTATE_LEFT,
      operand_address_sequencer_pkg::OPER_BIT_TEST,
      operand_address_sequencer_pkg::OPER_INCREMENT,
      operand_address_sequencer_pkg::OPER_DECREMENT,
      operand_address_sequencer_pkg::OPER_STORE_ACC,
      operand_address_sequencer_pkg::OPER_STORE_X,
      operand_address_sequencer_pkg::OPER_STORE_Y:
        ok = (m == operand_address_sequencer_pkg::MODE_ABSOLUTE) ||
             (m == operand_address_sequencer_pkg::MODE_ZERO_PAGE);
      operand_address_sequencer_pkg::OPER_JUMP,
      operand_address_sequencer_pkg::OPER_CALL:
        ok = (m == operand_address_sequencer_pkg::MODE_ABSOLUTE);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_store(
    input operand_address_sequencer_pkg::operation_t op
  );
    return (op == operand_address_sequencer_pkg::OPER_STORE_ACC) ||
           (op == operand_address_sequencer_pkg::OPER_STORE_X) ||
           (op == operand_address_sequencer_pkg::OPER_STORE_Y);
  endfunction

  // Picks the register that a store writes.
  function automatic logic [7:0] store_value(
    input operand_address_sequencer_pkg::operation_t op,
    input logic [7:0]                                acc,
    input logic [7:0]                                x,
    input logic [7:0]                                y
  );
    logic [7:0] v;
    v = acc;
    if (op == operand_address_sequencer_pkg::OPER_STORE_X)
    begin
      v = x;
    end
    else if (op == operand_address_sequencer_pkg::OPER_STORE_Y)
    begin
      v = y;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. The bus address for the coming cycle is formed here
  // so that it leaves the block straight from a flip-flop.
  always_comb
  begin
    cur_oper = operand_address_sequencer_pkg::operation_t'(
      r.opcode[operand_address_sequencer_pkg::OPER_MSB:
               operand_address_sequencer_pkg::OPER_LSB]);
    cur_mode = operand_address_sequencer_pkg::addr_mode_t'(
      r.opcode[operand_address_sequencer_pkg::MODE_MSB:
               operand_address_sequencer_pkg::MODE_LSB]);
    new_oper = operand_address_sequencer_pkg::operation_t'(
      read_data_i[operand_address_sequencer_pkg::OPER_MSB:
                  operand_address_sequencer_pkg::OPER_LSB]);
    new_mode = operand_address_sequencer_pkg::addr_mode_t'(
      read_data_i[operand_address_sequencer_pkg::MODE_MSB:
                  operand_address_sequencer_pkg::MODE_LSB]);
    counter_inc = r.program_counter_value +
                  operand_address_sequencer_pkg::COUNTER_STEP;
    next_r = r;
    next_r.write_enable = 1'b0;
    next_r.operand_valid = 1'b0;
    next_r.commit = 1'b0;
    next_r.illegal = 1'b0;
    next_r.opcode_fetch = 1'b0;
    unique case (r.state)
      operand_address_sequencer_pkg::ST_FETCH_OPCODE:
      begin
        next_r.opcode = read_data_i;
        next_r.program_counter_value = counter_inc;
        next_r.address = counter_inc;
        if (mode_allowed(new_oper, new_mode))
        begin
          next_r.state = operand_address_sequencer_pkg::ST_FETCH_LOW;
        end
        else
        begin
          next_r.state = operand_address_sequencer_pkg::ST_DECODE_ONLY;
          next_r.illegal = 1'b1;
        end
      end
      operand_address_sequencer_pkg::ST_FETCH_LOW:
      begin
        next_r.program_counter_value = counter_inc;
        next_r.effective_address_low_byte = read_data_i;
        unique case (cur_mode)
          operand_address_sequencer_pkg::MODE_IMMEDIATE:
          begin
            next_r.operand = read_data_i;
            next_r.operand_valid = 1'b1;
            next_r.address = counter_inc;
            next_r.state = operand_address_sequencer_pkg::ST_FETCH_OPCODE;
            next_r.commit = 1'b1;
            next_r.opcode_fetch = 1'b1;
          end
          operand_address_sequencer_pkg::MODE_ABSOLUTE:
          begin
            next_r.address = counter_inc;
            next_r.state = operand_address_sequencer_pkg::ST_FETCH_HIGH;
          end
          operand_address_sequencer_pkg::MODE_ZERO_PAGE,
          operand_address_sequencer_pkg::MODE_OTHER:
          begin
            next_r.address = {operand_address_sequencer_pkg::ZERO_PAGE_HIGH,
                              read_data_i};
            next_r.write_enable = is_store(cur_oper);
            next_r.write_data = store_value(cur_oper, accumulator_i,
                                            index_x_i, index_y_i);
            next_r.state = operand_address_sequencer_pkg::ST_OPERAND;
          end
        endcase
      end
      operand_address_sequencer_pkg::ST_FETCH_HIGH:
      begin
        if ((cur_oper == operand_address_sequencer_pkg::OPER_JUMP) ||
            (cur_oper == operand_address_sequencer_pkg::OPER_CALL))
        begin
          next_r.program_counter_value = {read_data_i,
                                          r.effective_address_low_byte};
          next_r.address = {read_data_i, r.effective_address_low_byte};
          next_r.state = operand_address_sequencer_pkg::ST_FETCH_OPCODE;
          next_r.commit = 1'b1;
          next_r.opcode_fetch = 1'b1;
        end
        else
        begin
          next_r.program_counter_value = counter_inc;
          next_r.address = {read_data_i, r.effective_address_low_byte};
          next_r.write_enable = is_store(cur_oper);
          next_r.write_data = store_value(cur_oper, accumulator_i,
                                          index_x_i, index_y_i);
          next_r.state = operand_address_sequencer_pkg::ST_OPERAND;
        end
      end
      operand_address_sequencer_pkg::ST_OPERAND:
      begin
        if (!r.write_enable)
        begin
          next_r.operand = read_data_i;
          next_r.operand_valid = 1'b1;
        end
        next_r.address = r.program_counter_value;
        next_r.state = operand_address_sequencer_pkg::ST_FETCH_OPCODE;
        next_r.commit = 1'b1;
        next_r.opcode_fetch = 1'b1;
      end
      operand_address_sequencer_pkg::ST_DECODE_ONLY:
      begin
        // The counter is not advanced: the byte just read is refetched.
        next_r.address = r.program_counter_value;
        next_r.state = operand_address_sequencer_pkg::ST_FETCH_OPCODE;
        next_r.commit = 1'b1;
        next_r.opcode_fetch = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      r <= REGS_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken from the state register.
  // commit during opcode fetch
  assign commit_o = r.commit;
  assign address_o = r.address;
  assign write_data_o = r.write_data;
  assign write_enable_o = r.write_enable;
  assign opcode_fetch_o = r.opcode_fetch;
  assign opcode_o = r.opcode;
  assign operand_o = r.operand;
  assign operand_valid_o = r.operand_valid;
  assign illegal_opcode_o = r.illegal;

endmodule // operand_address_sequencer

//--- src/operand_address_sequencer_pkg.sv
package operand_address_sequencer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PAGE_BITS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and address constants.
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_STEP = 16'h0001;
  localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode byte layout: operation in the upper six bits, mode in the lower two.
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int OPER_LSB = 2;
  localparam int OPER_MSB = 7;

  typedef enum logic [1:0] {
    MODE_IMMEDIATE,
    MODE_ABSOLUTE,
    MODE_ZERO_PAGE,
    MODE_OTHER
  } addr_mode_t;

  typedef enum logic [5:0] {
    OPER_ADD,
    OPER_SUB,
    OPER_AND,
    OPER_OR,
    OPER_XOR,
    OPER_CMP_ACC,
    OPER_CMP_X,
    OPER_CMP_Y,
    OPER_LOAD_ACC,
    OPER_LOAD_X,
    OPER_LOAD_Y,
    OPER_SHIFT_LEFT,
    OPER_SHIFT_RIGHT,
    OPER_ROTATE_LEFT,
    OPER_BIT_TEST,
    OPER_INCREMENT,
    OPER_DECREMENT,
    OPER_STORE_ACC,
    OPER_STORE_X,
    OPER_STORE_Y,
    OPER_JUMP,
    OPER_CALL
  } operation_t;

  typedef enum logic [2:0] {
    ST_FETCH_OPCODE,
    ST_FETCH_LOW,
    ST_FETCH_HIGH,
    ST_OPERAND,
    ST_DECODE_ONLY
  } seq_state_t;

endpackage

//--- tb/mem_model.sv
module mem_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] address_i,
  input  wire logic [7:0]  write_data_i,
  input  wire logic        write_enable_i,
  output logic      [7:0]  read_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8);
  end
  assign read_data_o = mem[address_i];
  always @(posedge clock_i)
  begin
    if (write_enable_i === 1'b1)
      mem[address_i] <= write_data_i;
  end
  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule // mem_model

//--- tb/operand_address_sequencer_asserts.sv
module operand_address_sequencer_asserts (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  read_data_i,
  input wire logic [7:0]  accumulator_i,
  input wire logic [7:0]  index_x_i,
  input wire logic [7:0]  index_y_i,
  input wire logic [15:0] address_o,
  input wire logic [7:0]  write_data_o,
  input wire logic        write_enable_o,
  input wire logic        opcode_fetch_o,
  input wire logic        commit_o,
  input wire logic [7:0]  opcode_o,
  input wire logic [7:0]  operand_o,
  input wire logic        operand_valid_o,
  input wire logic        illegal_opcode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [5:0] op;
  logic [1:0] md;
  logic       imm;
  logic       zp;
  logic       ab;
  logic       jp;
  logic       fe;
  assign op  = read_data_i[7:2];
  assign md  = read_data_i[1:0];
  assign imm = md == 2'h0 && op < 6'h0B;
  assign zp  = md == 2'h2 && op < 6'h14;
  assign ab  = md == 2'h1 && op < 6'h14;
  assign jp  = md == 2'h1 && (op == 6'h14 || op == 6'h15);
  assign fe  = opcode_fetch_o;
  ////////////////////////////////////////////////////////////////////////////
  a_reset_fetch:
    assert property ($rose(nrst_i) |-> fe && !commit_o
      && address_o == 16'h0000) else $error("bad first fetch");
  a_imm_seq:
    assert property (fe && imm |=> address_o == $past(address_o) + 16'h0001
      && !fe ##1 fe && commit_o && operand_valid_o
      && address_o == $past(address_o, 2) + 16'h0002)
    else $error("immediate sequence wrong");
  a_zero_page_seq:
    assert property (fe && zp |=> address_o == $past(address_o) + 16'h0001
      ##1 !fe && address_o == {8'h00, $past(read_data_i)}
      ##1 fe && commit_o && address_o == $past(address_o, 3) + 16'h0002)
    else $error("zero page sequence wrong");
  a_absolute_seq:
    assert property (fe && ab |=> address_o == $past(address_o) + 16'h0001
      ##1 !fe && address_o == $past(address_o) + 16'h0001
      ##1 !fe && address_o == {$past(read_data_i), $past(read_data_i, 2)}
      ##1 fe && address_o == $past(address_o, 4) + 16'h0003)
    else $error("absolute sequence wrong");
  a_jump_target:
    assert property (fe && jp |=> !fe ##1 !fe ##1 fe && commit_o
      && address_o == {$past(read_data_i), $past(read_data_i, 2)})
    else $error("jump target wrong");
  a_illegal_refused:
    assert property (fe && !(imm || zp || ab || jp) |=> illegal_opcode_o
      && address_o == $past(address_o) + 16'h0001
      ##1 fe && address_o == $past(address_o))
    else $error("illegal opcode handling wrong");
  a_store_data:
    assert property (write_enable_o |-> !fe && opcode_o[7:2] > 6'h10
      && opcode_o[7:2] < 6'h14 && write_data_o == (opcode_o[7:2] == 6'h11
      ? $past(accumulator_i) : opcode_o[7:2] == 6'h12 ? $past(index_x_i)
      : $past(index_y_i))) else $error("store data wrong");
  a_operand_data:
    assert property (operand_valid_o |-> operand_o == $past(read_data_i))
    else $error("operand byte wrong");
  a_two_cycles_min:
    assert property (fe |=> !fe) else $error("instruction too short");
  a_commit_in_fetch:
    assert property (commit_o |-> fe) else $error("commit outside fetch");
  c_imm: cover property (fe && imm);
  c_store: cover property (write_enable_o);
  c_jump: cover property (fe && jp);
  c_illegal: cover property (illegal_opcode_o);
endmodule // operand_address_sequencer_asserts

bind operand_address_sequencer operand_address_sequencer_asserts chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .read_data_i(read_data_i),
  .accumulator_i(accumulator_i), .index_x_i(index_x_i),
  .index_y_i(index_y_i), .address_o(address_o),
  .write_data_o(write_data_o), .write_enable_o(write_enable_o),
  .opcode_fetch_o(opcode_fetch_o), .commit_o(commit_o),
  .opcode_o(opcode_o), .operand_o(operand_o),
  .operand_valid_o(operand_valid_o), .illegal_opcode_o(illegal_opcode_o));

//--- tb/tb.sv
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++;\
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] a;
    logic        w;
    logic        f;
    logic        c;
    logic        k;
    logic [7:0]  v;
    logic        x;
  } exp_t;
  logic        clock_i;
  logic        nrst_i;
  logic        we;
  logic        fe;
  logic        cm;
  logic        ov;
  logic        first;
  logic        pk;
  logic        ill;
  logic        il;
  logic [7:0]  rd;
  logic [7:0]  acc;
  logic [7:0]  ix;
  logic [7:0]  iy;
  logic [7:0]  wd;
  logic [7:0]  opd;
  logic [7:0]  pend;
  logic [15:0] ad;
  logic [15:0] cur;
  exp_t        q[$];
  exp_t        prog[$];
  int          miscompares;
  int          cmp_count;
  operand_address_sequencer dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .read_data_i(rd),
    .accumulator_i(acc), .index_x_i(ix), .index_y_i(iy), .address_o(ad),
    .write_data_o(wd), .write_enable_o(we), .opcode_fetch_o(fe),
    .commit_o(cm), .opcode_o(), .operand_o(opd), .operand_valid_o(ov),
    .illegal_opcode_o(il));
  mem_model mem (.clock_i(clock_i), .address_i(ad), .write_data_i(wd),
    .write_enable_i(we), .read_data_o(rd));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic legal(input logic [5:0] op, input logic [1:0] md);
    return (md == 2'h0 && op < 6'h0B) || (md == 2'h1 && op < 6'h16)
      || (md == 2'h2 && op < 6'h14);
  endfunction
  // Register that a store of the given operation code must write.
  function automatic logic [7:0] store_exp(input logic [7:0] code);
    return code == 8'h11 ? acc : code == 8'h12 ? ix : iy;
  endfunction
  task automatic put(input logic [15:0] a, input logic w, input logic f,
                     input logic [7:0] v);
    exp_t e;
    e = '{a: a, w: w, f: f, c: f && !first, k: f && pk, v: f ? pend : v,
          x: ill};
    prog.push_back(e);
    if (f)
    begin
      first = 1'b0;
      pk = 1'b0;
    end
  endtask
  // Places one instruction at pc and appends the bus cycles it must make.
  task automatic emit(input logic [5:0] op, input logic [1:0] md,
                      input logic [7:0] b1, input logic [7:0] b2);
    mem.poke(cur, {op, md});
    mem.poke(cur + 16'h0001, b1);
    mem.poke(cur + 16'h0002, b2);
    put(cur, 1'b0, 1'b1, 8'h00);
    ill = !legal(op, md);
    put(cur + 16'h0001, 1'b0, 1'b0, 8'h00);
    ill = 1'b0;
    if (!legal(op, md))
      cur = cur + 16'h0001;
    else if (md == 2'h0)
    begin
      pend = b1;
      pk = 1'b1;
      cur = cur + 16'h0002;
    end
    else if (md == 2'h2)
    begin
      put({8'h00, b1}, op > 6'h10, 1'b0, {2'b00, op});
      cur = cur + 16'h0002;
    end
    else
    begin
      put(cur + 16'h0002, 1'b0, 1'b0, 8'h00);
      if (op > 6'h13)
        cur = {b2, b1};
      else
      begin
        put({b2, b1}, op > 6'h10, 1'b0, {2'b00, op});
        cur = cur + 16'h0003;
      end
    end
  endtask
  task automatic run(input int n);
    exp_t e;
    q = prog;
    repeat (n)
    begin
      e = q.pop_front();
      `CHK("address", e.a, ad)
      `CHK("write", e.w, we)
      `CHK("fetch", e.f, fe)
      `CHK("commit", e.c, cm)
      `CHK("illegal", e.x, il)
      if (e.k) `CHK("operand", {1'b1, e.v}, {ov, opd})
      if (e.w) `CHK("store", store_exp(e.v), wd)
      acc = 8'($urandom);
      ix = 8'($urandom);
      iy = 8'($urandom);
      @(negedge clock_i);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #100us;
    miscompares++;
    finish_test();
  end
  initial
  begin
    logic [5:0]  op;
    logic [1:0]  md;
    logic [15:0] t;
    void'($urandom(78291));
    {nrst_i, acc, ix, iy, pend, pk, ill} = '0;
    {miscompares, cmp_count} = '0;
    first = 1'b1;
    #1;
    cur = 16'h0000;
    emit(6'h14, 2'h1, 8'h00, 8'h80);
    emit(6'h08, 2'h0, 8'h5A, 8'h00);
    emit(6'h0B, 2'h0, 8'h00, 8'h00);
    emit(6'h15, 2'h2, 8'h20, 8'h00);
    emit(6'h11, 2'h2, 8'hFF, 8'h00);
    emit(6'h08, 2'h1, 8'hFF, 8'hFF);
    emit(6'h13, 2'h1, 8'h00, 8'h40);
    // Every operation in every mode first, then random instructions.
    for (int i = 0; i < 250; i++)
    begin
      op = i < 96 ? 6'(i / 4) : 6'($urandom % 24);
      md = i < 96 ? 2'(i) : 2'($urandom);
      t = cur + 16'h0040 + 16'($urandom % 64);
      if (md == 2'h1 && op > 6'h13)
        emit(op, md, t[7:0], t[15:8]);
      else
        emit(op, md, 8'h10 + 8'($urandom % 240), 8'h10 + 8'($urandom % 96));
    end
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    run(prog.size() / 2);
    nrst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    run(prog.size());
    finish_test();
  end
endmodule // tb
